// ### design/fdmsc_ctrl.sv
// Mode, over-voltage, LED failure and start-up control of a flash driver.
// Assumes the analog loop reports its conditions as pin-level inputs.
// Operation
// - Shorted LED: clamp current, set failure flag
// - Open LED: limit voltage, set failure flag
// - Low threshold only direct drive, code 0-4
// - Force pin gives voltage mode, fixed target
// - Mode 00 unforced: shutdown, load disconnected in direct drive only
// - Mode 01 unforced: DC light, current regulation
// - Mode 10 unforced: current regulation, flash ready
// - Mode 10 high-current: stage off during strobe
// - Mode 11 or forced 00: voltage regulation
// - Forced 01: voltage regulation plus DC light
// - Forced 10: voltage, flash ready, stage on
// - Enable starts limited pre-charge to threshold
// - Direct drive: three current-limit steps
// - Step two after 1 ms, full at regulation
// - Direct drive start-up: balancing disabled
// - High-current pre-charge level depends on mode
// - High-current down-mode: low limit by select
// - High-current boost: full limit with blanking
// - High-current start-up: balancing enabled
`timescale 1ns/10ps
`include "fdmsc_params.svh"
module fdmsc_ctrl #(
	parameter int STEP1_CYCLES = `FDMSC_STEP1_US * `FDMSC_CLK_MHZ
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Mode and configuration pins
	input wire logic [1:0] mode_i,
	input wire logic voltage_mode_force_i,
	input wire logic high_current_select_i,
	input wire logic current_limit_select_i,
	input wire logic [3:0] output_voltage_code_i,
	input wire logic tx_mask_i,
	input wire logic flash_strobe_i,
	// Analog condition pins
	input wire logic led_short_i,
	input wire logic led_open_i,
	input wire logic precharge_done_i,
	input wire logic in_boost_i,
	input wire logic vout_in_reg_i,
	input wire logic led_failure_clear_i,
	// Regulation controls
	output logic conv_en_o,
	output logic current_regulation_mode_o,
	output logic voltage_regulation_mode_o,
	output logic led_en_o,
	output logic flash_ready_o,
	output logic power_stage_en_o,
	output logic load_disconnect_o,
	output logic [3:0] vout_target_code_o,
	output logic ovp_high_o,
	output logic current_clamp_o,
	output logic voltage_limit_o,
	output logic led_failure_flag_o,
	// Start-up controls
	output logic precharge_o,
	output logic precharge_to_vin_o,
	output logic [1:0] current_limit_select_step_o,
	output logic current_limit_select_high_o,
	output logic balance_en_o,
	output logic [4:0] startup_state_o
);
	localparam int CW = $clog2(STEP1_CYCLES + 1);
	localparam logic [CW-1:0] STEP1_LAST = CW'(STEP1_CYCLES - 1);

	// Three-stage input synchronisers; pins are asynchronous
	logic [2:0] s_mode0, s_mode1, s_force, s_hc, s_current_limit_select, s_tx, s_strobe;
	logic [2:0] s_short, s_open, s_pre, s_boost, s_reg, s_clr;
	logic [3:0] s_ov0, s_ov1, s_ov2;
	always_ff @(posedge clk_sys_i) begin
		s_mode0 <= {s_mode0[1:0], mode_i[0]};
		s_mode1 <= {s_mode1[1:0], mode_i[1]};
		s_force <= {s_force[1:0], voltage_mode_force_i};
		s_hc <= {s_hc[1:0], high_current_select_i};
		s_current_limit_select <= {s_current_limit_select[1:0], current_limit_select_i};
		s_tx <= {s_tx[1:0], tx_mask_i};
		s_strobe <= {s_strobe[1:0], flash_strobe_i};
		s_short <= {s_short[1:0], led_short_i};
		s_open <= {s_open[1:0], led_open_i};
		s_pre <= {s_pre[1:0], precharge_done_i};
		s_boost <= {s_boost[1:0], in_boost_i};
		s_reg <= {s_reg[1:0], vout_in_reg_i};
		s_clr <= {s_clr[1:0], led_failure_clear_i};
		s_ov0 <= output_voltage_code_i;
		s_ov1 <= s_ov0;
		s_ov2 <= s_ov1;
	end

	// Filtered levels: change accepted when stages two and three agree
	logic f_m0, f_m1, f_force, f_hc, f_current_limit_select, f_tx, f_strobe;
	logic f_short, f_open, f_pre, f_boost, f_reg, f_clr;
	logic [3:0] f_ov;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			f_m0 <= 1'b0;
			f_m1 <= 1'b0;
			f_force <= 1'b0;
			f_hc <= 1'b0;
			f_current_limit_select <= 1'b0;
			f_tx <= 1'b0;
			f_strobe <= 1'b0;
			f_short <= 1'b0;
			f_open <= 1'b0;
			f_pre <= 1'b0;
			f_boost <= 1'b0;
			f_reg <= 1'b0;
			f_clr <= 1'b0;
			f_ov <= 4'h0;
		end else begin
			if (s_mode0[1] == s_mode0[2]) f_m0 <= s_mode0[2];
			if (s_mode1[1] == s_mode1[2]) f_m1 <= s_mode1[2];
			if (s_force[1] == s_force[2]) f_force <= s_force[2];
			if (s_hc[1] == s_hc[2]) f_hc <= s_hc[2];
			if (s_current_limit_select[1] == s_current_limit_select[2]) f_current_limit_select <= s_current_limit_select[2];
			if (s_tx[1] == s_tx[2]) f_tx <= s_tx[2];
			if (s_strobe[1] == s_strobe[2]) f_strobe <= s_strobe[2];
			if (s_short[1] == s_short[2]) f_short <= s_short[2];
			if (s_open[1] == s_open[2]) f_open <= s_open[2];
			if (s_pre[1] == s_pre[2]) f_pre <= s_pre[2];
			if (s_boost[1] == s_boost[2]) f_boost <= s_boost[2];
			if (s_reg[1] == s_reg[2]) f_reg <= s_reg[2];
			if (s_clr[1] == s_clr[2]) f_clr <= s_clr[2];
			if (s_ov1 == s_ov2) f_ov <= s_ov2;
		end
	end

	// Mode decode
	fdmsc_decode_if dif ();
	fdmsc_mode_decode u_dec (
		.mode_i ({f_m1, f_m0}),
		.voltage_mode_force_i (f_force),
		.dec (dif.dec)
	);

	// Current-limit select is latched only while idle in shutdown
	logic current_limit_select_sel;
	fdmsc_pkg::fdmsc_state_e state;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			current_limit_select_sel <= 1'b0;
		else if (state == fdmsc_pkg::FDMSC_IDLE)
			current_limit_select_sel <= f_current_limit_select;
	end

	// Registered regulation controls
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			conv_en_o <= 1'b0;
			current_regulation_mode_o <= 1'b0;
			voltage_regulation_mode_o <= 1'b0;
			led_en_o <= 1'b0;
			flash_ready_o <= 1'b0;
			load_disconnect_o <= 1'b1;
			vout_target_code_o <= 4'h0;
		end else begin
			conv_en_o <= dif.conv_en;
			current_regulation_mode_o <= dif.cur_reg;
			voltage_regulation_mode_o <= dif.volt_reg;
			led_en_o <= dif.led_en;
			flash_ready_o <= dif.flash_ready;
			load_disconnect_o <= !dif.conv_en && !f_hc;
			vout_target_code_o <= dif.force_target ?
				`FDMSC_OV_FORCE_CODE : f_ov;
		end
	end

	// Power stage gating during a high-current strobe
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			power_stage_en_o <= 1'b0;
		else if (!dif.conv_en)
			power_stage_en_o <= 1'b0;
		else if (dif.cur_reg && dif.flash_ready && f_hc && f_strobe)
			power_stage_en_o <= 1'b0;
		else
			power_stage_en_o <= (state != fdmsc_pkg::FDMSC_PRECHG);
	end

	// Over-voltage threshold choice
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			ovp_high_o <= 1'b1;
		else
			ovp_high_o <= f_hc || (f_ov > `FDMSC_OV_LOW_MAX);
	end

	// LED failure: clamp, limit and sticky flag, set beats clear
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			current_clamp_o <= 1'b0;
			voltage_limit_o <= 1'b0;
			led_failure_flag_o <= 1'b0;
		end else begin
			current_clamp_o <= f_short && led_en_o;
			voltage_limit_o <= f_open && led_en_o;
			if (led_en_o && (f_short || f_open))
				led_failure_flag_o <= 1'b1;
			else if (f_clr)
				led_failure_flag_o <= 1'b0;
		end
	end

	// Start-up sequencer
	logic [CW-1:0] step_cnt;
	logic was_en;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state <= fdmsc_pkg::FDMSC_IDLE;
			was_en <= 1'b0;
			step_cnt <= '0;
		end else begin
			was_en <= dif.conv_en;
			if (!dif.conv_en) begin
				state <= fdmsc_pkg::FDMSC_IDLE;
			end else begin
				unique case (state)
					fdmsc_pkg::FDMSC_IDLE: begin
						if (!was_en)
							state <= fdmsc_pkg::FDMSC_PRECHG;
					end
					fdmsc_pkg::FDMSC_PRECHG: begin
						step_cnt <= '0;
						if (f_pre)
							state <= f_hc ? fdmsc_pkg::FDMSC_STEP2 :
								fdmsc_pkg::FDMSC_STEP1;
					end
					fdmsc_pkg::FDMSC_STEP1: begin
						step_cnt <= step_cnt + 1'b1;
						if (step_cnt == STEP1_LAST)
							state <= fdmsc_pkg::FDMSC_STEP2;
					end
					fdmsc_pkg::FDMSC_STEP2: begin
						if (f_hc ? f_boost : f_reg)
							state <= fdmsc_pkg::FDMSC_RUN;
					end
					fdmsc_pkg::FDMSC_RUN: begin
						state <= fdmsc_pkg::FDMSC_RUN;
					end
					default: state <= fdmsc_pkg::FDMSC_IDLE;
				endcase
			end
		end
	end

	// Start-up outputs
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			precharge_o <= 1'b0;
			precharge_to_vin_o <= 1'b0;
			current_limit_select_step_o <= `FDMSC_CURRENT_LIMIT_SELECT_STEP1;
			current_limit_select_high_o <= 1'b0;
			balance_en_o <= 1'b0;
			startup_state_o <= fdmsc_pkg::FDMSC_IDLE;
		end else begin
			startup_state_o <= state;
			precharge_o <= (state == fdmsc_pkg::FDMSC_PRECHG);
			precharge_to_vin_o <= f_hc && dif.excl_cur;
			balance_en_o <= f_hc;
			unique case (state)
				fdmsc_pkg::FDMSC_STEP1: begin
					current_limit_select_step_o <= `FDMSC_CURRENT_LIMIT_SELECT_STEP1;
					current_limit_select_high_o <= 1'b0;
				end
				fdmsc_pkg::FDMSC_STEP2: begin
					current_limit_select_step_o <= f_hc ? `FDMSC_CURRENT_LIMIT_SELECT_HC_LOW :
						`FDMSC_CURRENT_LIMIT_SELECT_STEP2;
					current_limit_select_high_o <= f_hc ? current_limit_select_sel : 1'b0;
				end
				fdmsc_pkg::FDMSC_RUN: begin
					current_limit_select_step_o <= (f_hc && f_tx) ? `FDMSC_CURRENT_LIMIT_SELECT_HC_LOW :
						`FDMSC_CURRENT_LIMIT_SELECT_FULL;
					current_limit_select_high_o <= current_limit_select_sel;
				end
				default: begin
					current_limit_select_step_o <= `FDMSC_CURRENT_LIMIT_SELECT_STEP1;
					current_limit_select_high_o <= 1'b0;
				end
			endcase
		end
	end

	// Assertions
	property p_ovp_low;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!f_hc && f_ov <= `FDMSC_OV_LOW_MAX) |=> !ovp_high_o;
	endproperty
	a_ovp_low: assert property (p_ovp_low) else $error("ovp low");
	property p_flag;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(led_en_o && f_short) |=> led_failure_flag_o && current_clamp_o;
	endproperty
	a_flag: assert property (p_flag) else $error("flag");
	property p_open;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(led_en_o && f_open) |=> voltage_limit_o && led_failure_flag_o;
	endproperty
	a_open: assert property (p_open) else $error("open");
	property p_force;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		f_force |=> voltage_regulation_mode_o &&
			vout_target_code_o == `FDMSC_OV_FORCE_CODE;
	endproperty
	a_force: assert property (p_force) else $error("force");
	property p_off;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!f_force && {f_m1, f_m0} == `FDMSC_MODE_OFF) |=> !conv_en_o;
	endproperty
	a_off: assert property (p_off) else $error("off");
	property p_strobe;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!f_force && {f_m1, f_m0} == `FDMSC_MODE_FLASH && f_hc && f_strobe)
			|=> !power_stage_en_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe");
	sequence s_enter;
		state == fdmsc_pkg::FDMSC_IDLE && dif.conv_en && !was_en;
	endsequence
	property p_restart;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_enter |=> state == fdmsc_pkg::FDMSC_PRECHG ##1 precharge_o;
	endproperty
	a_restart: assert property (p_restart) else $error("restart");
	property p_step;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == fdmsc_pkg::FDMSC_STEP1 && step_cnt == STEP1_LAST &&
			dif.conv_en) |=> state == fdmsc_pkg::FDMSC_STEP2;
	endproperty
	a_step: assert property (p_step) else $error("step");
	property p_bal;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(f_hc) |=> balance_en_o == $past(f_hc);
	endproperty
	a_bal: assert property (p_bal) else $error("balance");
endmodule : fdmsc_ctrl

// ### design/fdmsc_decode_if.sv
// Decoded mode controls passed from the decoder to the main module.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface fdmsc_decode_if;
	logic conv_en;
	logic cur_reg;
	logic volt_reg;
	logic led_en;
	logic flash_ready;
	logic force_target;
	logic excl_cur;
	modport dec (output conv_en, cur_reg, volt_reg, led_en, flash_ready,
		force_target, excl_cur);
	modport use_end (input conv_en, cur_reg, volt_reg, led_en, flash_ready,
		force_target, excl_cur);
endinterface : fdmsc_decode_if

// ### design/fdmsc_mode_decode.sv
// Combinational decode of mode bits and the voltage-mode force.
// Assumes synchronised inputs; outputs are registered by the user.
`timescale 1ns/10ps
`include "fdmsc_params.svh"
module fdmsc_mode_decode (
	// Mode inputs
	input wire logic [1:0] mode_i,
	input wire logic voltage_mode_force_i,
	// Decoded controls
	fdmsc_decode_if.dec dec
);
	// Mode table decode
	always_comb begin
		dec.conv_en = 1'b1;
		dec.cur_reg = 1'b0;
		dec.volt_reg = 1'b0;
		dec.led_en = 1'b0;
		dec.flash_ready = 1'b0;
		dec.force_target = voltage_mode_force_i;
		dec.excl_cur = 1'b0;
		if (voltage_mode_force_i) begin
			dec.volt_reg = 1'b1;
			dec.led_en = (mode_i == `FDMSC_MODE_DCL) ||
				(mode_i == `FDMSC_MODE_FLASH);
			dec.flash_ready = (mode_i == `FDMSC_MODE_FLASH);
		end else begin
			unique case (mode_i)
				`FDMSC_MODE_OFF: begin
					dec.conv_en = 1'b0;
				end
				`FDMSC_MODE_DCL: begin
					dec.cur_reg = 1'b1;
					dec.led_en = 1'b1;
					dec.excl_cur = 1'b1;
				end
				`FDMSC_MODE_FLASH: begin
					dec.cur_reg = 1'b1;
					dec.led_en = 1'b1;
					dec.flash_ready = 1'b1;
					dec.excl_cur = 1'b1;
				end
				`FDMSC_MODE_VREG: begin
					dec.volt_reg = 1'b1;
				end
			endcase
		end
	end
endmodule : fdmsc_mode_decode

// ### design/fdmsc_params.svh
// Constants for the flash driver mode and start-up control block.
// Assumes inclusion by the block's design modules and its bench.
`ifndef FDMSC_PARAMS_SVH
`define FDMSC_PARAMS_SVH

// Mode bit encodings
`define FDMSC_MODE_OFF 2'b00
`define FDMSC_MODE_DCL 2'b01
`define FDMSC_MODE_FLASH 2'b10
`define FDMSC_MODE_VREG 2'b11

// Highest output voltage code that allows the low over-voltage threshold
`define FDMSC_OV_LOW_MAX 4'h4

// Output voltage code meaning the fixed forced-voltage target
`define FDMSC_OV_FORCE_CODE 4'h6

// Current-limit step codes
`define FDMSC_CURRENT_LIMIT_SELECT_STEP1 2'b00
`define FDMSC_CURRENT_LIMIT_SELECT_STEP2 2'b01
`define FDMSC_CURRENT_LIMIT_SELECT_FULL 2'b10
`define FDMSC_CURRENT_LIMIT_SELECT_HC_LOW 2'b11

// First step length in microseconds, and the clock rate in MHz
`define FDMSC_STEP1_US 1000
`define FDMSC_CLK_MHZ 250

`endif

// ### design/fdmsc_pkg.sv
// Types shared by the flash driver mode and start-up control modules.
// Assumes fdmsc_params.svh sits beside it.
package fdmsc_pkg;
	// Start-up sequencer states, one-hot
	typedef enum logic [4:0] {
		FDMSC_IDLE = 5'h01,
		FDMSC_PRECHG = 5'h02,
		FDMSC_STEP1 = 5'h04,
		FDMSC_STEP2 = 5'h08,
		FDMSC_RUN = 5'h10
	} fdmsc_state_e;
endpackage : fdmsc_pkg

// ### sim/fdmsc_host_model.sv
// Host model: drives mode, force, select and voltage code pins.
// Assumes the bench calls its tasks; pins move on falling edges.
`timescale 1ns/10ps
module fdmsc_host_model (
	// Clock
	input wire logic clk_sys_i,
	// Configuration pins
	output logic [1:0] mode_o,
	output logic voltage_mode_force_o,
	output logic high_current_select_o,
	output logic current_limit_select_o,
	output logic [3:0] output_voltage_code_o
);
	// Pins idle at time zero
	initial begin
		mode_o = 2'h0;
		voltage_mode_force_o = 1'b0;
		high_current_select_o = 1'b0;
		current_limit_select_o = 1'b0;
		output_voltage_code_o = 4'h0;
	end

	// Write mode, force, select and voltage code together
	task automatic set_cfg(input logic [1:0] m, input logic f,
		input logic h, input logic [3:0] v);
		@(negedge clk_sys_i);
		mode_o = m;
		voltage_mode_force_o = f;
		high_current_select_o = h;
		output_voltage_code_o = v;
	endtask : set_cfg

	// Limit select only written while shutdown is programmed
	task automatic set_current_limit_select(input logic s);
		@(negedge clk_sys_i);
		if (mode_o == 2'h0 && !voltage_mode_force_o) begin
			current_limit_select_o = s;
		end
	endtask : set_current_limit_select
endmodule : fdmsc_host_model

// ### sim/tb.sv
// Bench: checks mode decode, thresholds, faults and start-up.
// Assumes the design package and header are on the include path.
`timescale 1ns/10ps
`include "fdmsc_params.svh"
module tb;
	typedef struct {int s; logic [7:0] e;} fdmsc_note_s;
	logic clk_sys_i, rst_n_i;
	logic [1:0] mode;
	logic vmf, hcs, cls;
	logic [3:0] ovc, vt;
	logic tx, strb, lsh, lop, pcd, bst, inr, fcl;
	logic conv, cur, volt, led, fr, pse, ldis, ovp, clmp, vlim, flag;
	logic pc, pcv, ilh, bal;
	logic [1:0] ils;
	logic [4:0] st;
	logic [7:0] obs [18];
	string nm [18] = '{"conv", "cur", "volt", "led", "fr", "pse", "ldis",
		"vt", "ovp", "clmp", "vlim", "flag", "pc", "pcv", "ils", "ilh",
		"bal", "st"};
	fdmsc_note_s q [$];
	fdmsc_note_s n;
	event chk_ev;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [31:0] rnd = 32'h4f7c;
	logic [1:0] m;
	logic f, h, sd, sel;
	logic [3:0] v;
	localparam int STEP1_N = 8;

	fdmsc_host_model u_host (.clk_sys_i(clk_sys_i), .mode_o(mode),
		.voltage_mode_force_o(vmf), .high_current_select_o(hcs),
		.current_limit_select_o(cls), .output_voltage_code_o(ovc));

	fdmsc_ctrl #(.STEP1_CYCLES(STEP1_N)) u_dut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .mode_i(mode), .voltage_mode_force_i(vmf),
		.high_current_select_i(hcs), .current_limit_select_i(cls),
		.output_voltage_code_i(ovc), .tx_mask_i(tx), .flash_strobe_i(strb),
		.led_short_i(lsh), .led_open_i(lop), .precharge_done_i(pcd),
		.in_boost_i(bst), .vout_in_reg_i(inr), .led_failure_clear_i(fcl),
		.conv_en_o(conv), .current_regulation_mode_o(cur),
		.voltage_regulation_mode_o(volt), .led_en_o(led),
		.flash_ready_o(fr), .power_stage_en_o(pse),
		.load_disconnect_o(ldis), .vout_target_code_o(vt),
		.ovp_high_o(ovp), .current_clamp_o(clmp), .voltage_limit_o(vlim),
		.led_failure_flag_o(flag), .precharge_o(pc),
		.precharge_to_vin_o(pcv), .current_limit_select_step_o(ils), .current_limit_select_high_o(ilh),
		.balance_en_o(bal), .startup_state_o(st));

	// Observed outputs indexed by note selector
	always_comb obs = '{{7'h0, conv}, {7'h0, cur}, {7'h0, volt},
		{7'h0, led}, {7'h0, fr}, {7'h0, pse}, {7'h0, ldis}, {4'h0, vt},
		{7'h0, ovp}, {7'h0, clmp}, {7'h0, vlim}, {7'h0, flag},
		{7'h0, pc}, {7'h0, pcv}, {6'h0, ils}, {7'h0, ilh}, {7'h0, bal},
		{3'h0, st}};

	// Clock, 4 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask : cyc

	// Record an expected value for the monitor
	task automatic note(input int s, input logic [7:0] e);
		q.push_back('{s, e});
		->chk_ev;
	endtask : note

	task automatic compare_val(input int s, input logic [7:0] e);
		num_checks++;
		if (obs[s] !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm[s], e, obs[s]);
		end
	endtask : compare_val

	// Bounded wait for a sequencer state
	task automatic wait_st(input logic [4:0] w);
		int k;
		k = 0;
		while (st !== w && k < 2000) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (st !== w) begin
			n_mismatch++;
			$display("wrong value st exp %h got %h", w, st);
			wrap_up();
		end
	endtask : wait_st

	// Monitor takes the oldest note off the queue
	initial forever begin
		@(chk_ev);
		while (q.size() > 0) begin
			n = q.pop_front();
			compare_val(n.s, n.e);
		end
	end

	// Main sequence
	initial begin
		{tx, strb, lsh, lop, pcd, bst, inr, fcl} = 8'h00;
		rst_n_i = 1'b0;
		cyc(6);
		note(17, {3'h0, fdmsc_pkg::FDMSC_IDLE});
		note(6, 8'h01);
		cyc(3);
		rst_n_i = 1'b1;
		cyc(4);
		// Every mode, force and select combination
		for (int i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			m = i[1:0];
			f = i[2];
			h = i[3];
			v = rnd[3:0];
			u_host.set_cfg(m, f, h, v);
			cyc(8);
			sd = m == 2'h0 && !f;
			note(0, {7'h0, !sd});
			note(1, {7'h0, !f && (m == 2'h1 || m == 2'h2)});
			note(2, {7'h0, f || m == 2'h3});
			note(3, {7'h0, m == 2'h1 || m == 2'h2});
			note(4, {7'h0, m == 2'h2});
			note(6, {7'h0, sd && !h});
			if (f || m == 2'h3) begin
				note(7, {4'h0, f ? `FDMSC_OV_FORCE_CODE : v});
			end
			note(8, {7'h0, h || v > `FDMSC_OV_LOW_MAX});
		end
		// Direct drive start-up
		u_host.set_cfg(2'h0, 1'b0, 1'b0, 4'h3);
		wait_st(fdmsc_pkg::FDMSC_IDLE);
		sel = rnd[5];
		u_host.set_current_limit_select(sel);
		cyc(8);
		u_host.set_cfg(2'h1, 1'b0, 1'b0, 4'h3);
		wait_st(fdmsc_pkg::FDMSC_PRECHG);
		cyc(2);
		note(12, 8'h01);
		note(16, 8'h00);
		pcd = 1'b1;
		wait_st(fdmsc_pkg::FDMSC_STEP1);
		cyc(1);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_STEP1});
		// First step lasts exactly STEP1_N cycles
		cyc(STEP1_N - 2);
		note(17, {3'h0, fdmsc_pkg::FDMSC_STEP1});
		cyc(1);
		note(17, {3'h0, fdmsc_pkg::FDMSC_STEP2});
		wait_st(fdmsc_pkg::FDMSC_STEP2);
		cyc(1);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_STEP2});
		inr = 1'b1;
		wait_st(fdmsc_pkg::FDMSC_RUN);
		cyc(1);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_FULL});
		note(15, {7'h0, sel});
		// Shorted then open LED faults
		lsh = 1'b1;
		cyc(8);
		note(9, 8'h01);
		note(11, 8'h01);
		lsh = 1'b0;
		fcl = 1'b1;
		cyc(8);
		fcl = 1'b0;
		note(11, 8'h00);
		note(9, 8'h00);
		lop = 1'b1;
		cyc(8);
		note(10, 8'h01);
		note(11, 8'h01);
		lop = 1'b0;
		// Shutdown, then high-current start-up with new select
		{pcd, inr} = 2'b00;
		u_host.set_cfg(2'h0, 1'b0, 1'b1, 4'h3);
		wait_st(fdmsc_pkg::FDMSC_IDLE);
		u_host.set_current_limit_select(!sel);
		cyc(8);
		u_host.set_cfg(2'h2, 1'b0, 1'b1, 4'h3);
		wait_st(fdmsc_pkg::FDMSC_PRECHG);
		cyc(2);
		note(13, 8'h01);
		note(16, 8'h01);
		pcd = 1'b1;
		wait_st(fdmsc_pkg::FDMSC_STEP2);
		cyc(1);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_HC_LOW});
		note(15, {7'h0, !sel});
		bst = 1'b1;
		wait_st(fdmsc_pkg::FDMSC_RUN);
		cyc(1);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_FULL});
		tx = 1'b1;
		cyc(8);
		note(14, {6'h0, `FDMSC_CURRENT_LIMIT_SELECT_HC_LOW});
		note(5, 8'h01);
		tx = 1'b0;
		strb = 1'b1;
		cyc(8);
		note(5, 8'h00);
		u_host.set_cfg(2'h2, 1'b1, 1'b1, 4'h3);
		cyc(8);
		wait_st(fdmsc_pkg::FDMSC_RUN);
		cyc(2);
		note(5, 8'h01);
		cyc(2);
		wrap_up();
	end
endmodule : tb
